// >>> hdl/i2cmcp_device.sv
`timescale 1ns/1ps
`default_nettype none
// two-wire slave control port with its mode register bank
module i2cmcp_device (
  input  wire logic       CLK_IN,
  input  wire logic       RST_IN,
  i2cmcp_if.device        BUS,
  input  wire logic       ADDR_SEL_IN,
  output logic [5:0]      GAIN_CODE_OUT,
  output logic            MODE_REGS_RESTORE_OUT,
  output logic [2:0]      INPUT_CHANNEL_SEL_OUT,
  output logic            HPF_SKIP_OUT,
  output logic            SYSTEM_RESYNC_OUT,
  output logic            RESYNC_HOLD_OUT,
  output logic [1:0]      INTERFACE_ROLE_OUT,
  output logic [2:0]      DATA_FORMAT_SEL_OUT
);
  import i2cmcp_pkg::*;

  typedef struct packed {
    i2cmcp_dev_state_t st;        // protocol state
    i2cmcp_dev_state_t after;     // state once ack bit ends
    logic              scl_d;     // clock one cycle back
    logic              sda_d;     // data one cycle back
    logic [7:0]        shift;     // incoming byte
    logic [3:0]        cnt;       // bits taken in this byte
    logic [7:0]        idx;       // register_index
    logic              drive;     // pulling data low for ack
    logic              zero;      // constant low drive level
    logic [7:0]        r_gain;    // gain_and_restore
    logic [7:0]        r_chan;    // input_channel_select
    logic [7:0]        r_filt;    // filter_resync_interface
    logic              hold;      // converter held in resync
  } i2cmcp_dev_t;

  i2cmcp_dev_t q_reg;   // state
  i2cmcp_dev_t q_next;  // next state

  logic [2:0] pins_s;   // synchronised scl, sda, address select
  logic       scl_s;    // synchronised clock
  logic       sda_s;    // synchronised data
  logic       adr_s;    // synchronised address select
  logic       scl_rise; // clock rising edge seen
  logic       scl_fall; // clock falling edge seen
  logic       start_c;  // start condition seen
  logic       stop_c;   // stop condition seen
  logic [6:0] own_addr; // full slave address

  // all pins pass two flops before use
  i2cmcp_sync #(
    .WIDTH (3)
  ) u_sync (
    .CLK_IN   (CLK_IN),
    .RST_IN   (RST_IN),
    .ASYNC_IN ({BUS.scl_line, BUS.sda_line, ADDR_SEL_IN}),
    .SYNC_OUT (pins_s)
  );

  assign scl_s = pins_s[2];
  assign sda_s = pins_s[1];
  assign adr_s = pins_s[0];

  // bus events from the synchronised levels
  always_comb begin
    scl_rise = scl_s && !q_reg.scl_d;
    scl_fall = !scl_s && q_reg.scl_d;
    // data moving while clock stays high frames a transfer
    start_c  = scl_s && q_reg.scl_d && !sda_s && q_reg.sda_d;
    stop_c   = scl_s && q_reg.scl_d && sda_s && !q_reg.sda_d;
    own_addr = {DEV_ADDR_HI, adr_s};
  end

  // protocol engine and register writes
  always_comb begin
    q_next       = q_reg;
    q_next.scl_d = scl_s;
    q_next.sda_d = sda_s;
    q_next.zero  = 1'b0;
    if (start_c) begin
      // any start, also mid-transfer, restarts address phase
      q_next.st    = DEV_ADDR;
      q_next.cnt   = 4'h0;
      q_next.drive = 1'b0;
    end else if (stop_c) begin
      // stop ends everything, ack released
      q_next.st    = DEV_IDLE;
      q_next.drive = 1'b0;
    end else begin
      case (q_reg.st)
        DEV_ADDR, DEV_INDEX, DEV_DATA: begin
          if (scl_rise && q_reg.cnt != BYTE_CNT) begin
            // sample on rising clock, msb first
            q_next.shift = {q_reg.shift[BYTE_BITS-2:0], sda_s};
            q_next.cnt   = 4'(q_reg.cnt + 4'h1);
          end else if (scl_fall && q_reg.cnt == BYTE_CNT) begin
            // byte complete, decide on ack at clock fall
            q_next.cnt = 4'h0;
            case (q_reg.st)
              DEV_ADDR: begin
                // read bit on own address refused too
                if (q_reg.shift[7:1] == own_addr &&
                    !q_reg.shift[0]) begin
                  q_next.drive = 1'b1;
                  q_next.st    = DEV_ACK;
                  q_next.after = DEV_INDEX;
                end else begin
                  q_next.st = DEV_IGNORE;
                end
              end
              DEV_INDEX: begin
                // only the three defined indexes, 30h excluded
                if (q_reg.shift >= IDX_GAIN &&
                    q_reg.shift <= IDX_FILT) begin
                  q_next.idx   = q_reg.shift;
                  q_next.drive = 1'b1;
                  q_next.st    = DEV_ACK;
                  q_next.after = DEV_DATA;
                end else begin
                  q_next.st = DEV_IGNORE;
                end
              end
              default: begin
                // data byte: store into the current register
                if (q_reg.idx == IDX_GAIN) begin
                  if (!q_reg.shift[RESTORE_BIT]) begin
                    // restore written zero: whole bank to defaults
                    q_next.r_gain = RST_GAIN;
                    q_next.r_chan = RST_CHAN;
                    q_next.r_filt = RST_FILT;
                  end else begin
                    q_next.r_gain = q_reg.shift & MASK_GAIN;
                  end
                end else if (q_reg.idx == IDX_CHAN) begin
                  q_next.r_chan = q_reg.shift & MASK_CHAN;
                end else begin
                  q_next.r_filt = q_reg.shift & MASK_FILT;
                end
                // advance index, wrap inside the window
                if (q_reg.idx == IDX_FILT) begin
                  q_next.idx = IDX_GAIN;
                end else begin
                  q_next.idx = 8'(q_reg.idx + 8'h01);
                end
                q_next.drive = 1'b1;
                q_next.st    = DEV_ACK;
                q_next.after = DEV_DATA;
              end
            endcase
          end
        end
        DEV_ACK: begin
          // hold ack low through one clock, release at fall
          if (scl_fall) begin
            q_next.drive = 1'b0;
            q_next.st    = q_reg.after;
          end
        end
        default: begin
          // idle or refused: wait for next start or stop
          q_next.drive = 1'b0;
        end
      endcase
    end
    // resync bit zero holds the converter
    q_next.hold = !q_next.r_filt[RESYNC_BIT];
  end

  // state register
  always_ff @(posedge CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      q_reg        <= '0;
      q_reg.st     <= DEV_IDLE;
      q_reg.after  <= DEV_IDLE;
      q_reg.scl_d  <= 1'b1;
      q_reg.sda_d  <= 1'b1;
      q_reg.idx    <= IDX_GAIN;
      q_reg.r_gain <= RST_GAIN;
      q_reg.r_chan <= RST_CHAN;
      q_reg.r_filt <= RST_FILT;
      q_reg.hold   <= 1'b0;
    end else begin
      q_reg <= q_next;
    end
  end

  // bus drive, pulled low only during an ack
  assign BUS.sda_dev_out = q_reg.zero;
  assign BUS.sda_dev_oe  = q_reg.drive;

  // stored fields straight to the datapath controls
  assign GAIN_CODE_OUT         = q_reg.r_gain[GAIN_MSB:0];
  assign MODE_REGS_RESTORE_OUT = q_reg.r_gain[RESTORE_BIT];
  assign INPUT_CHANNEL_SEL_OUT = q_reg.r_chan[CHAN_MSB:0];
  assign HPF_SKIP_OUT          = q_reg.r_filt[SKIP_BIT];
  assign SYSTEM_RESYNC_OUT     = q_reg.r_filt[RESYNC_BIT];
  assign RESYNC_HOLD_OUT       = q_reg.hold;
  assign INTERFACE_ROLE_OUT    = q_reg.r_filt[ROLE_MSB:ROLE_LSB];
  assign DATA_FORMAT_SEL_OUT   = q_reg.r_filt[FMT_MSB:0];
endmodule // i2cmcp_device
`default_nettype wire

// >>> hdl/i2cmcp_host.sv
// The address-and-strobe port is this design's own decision.
`timescale 1ns/1ps
`default_nettype none
// two-wire write master with a small command register port
module i2cmcp_host #(
  parameter int QUARTER_CYC = i2cmcp_pkg::SCL_QUARTER_CYC
) (
  input  wire logic       CLK_IN,
  input  wire logic       RST_IN,
  i2cmcp_if.host          BUS,
  input  wire logic [2:0] ADDR_IN,
  input  wire logic [7:0] WDATA_IN,
  input  wire logic       WR_IN,
  input  wire logic       RD_IN,
  output logic [7:0]      RDATA_OUT,
  output logic            BUSY_OUT
);
  import i2cmcp_pkg::*;

  typedef struct packed {
    i2cmcp_host_state_t st;      // sequencer state
    logic [15:0]        tick;    // quarter-bit counter
    logic [1:0]         phase;   // quarter within a bit
    logic [2:0]         bitn;    // bit within byte
    logic [2:0]         byten;   // byte within transfer
    logic [7:0]         txb;     // byte being sent
    logic [7:0]         target;  // target address register
    logic [7:0]         index;   // index byte register
    logic [3:0][7:0]    data;    // data byte registers
    logic [1:0]         count;   // data bytes minus one
    logic               busy;    // transfer running
    logic               nack;    // missing ack seen
    logic [2:0]         acked;   // bytes acknowledged
    logic               scl_low; // pulling clock low
    logic               sda_low; // pulling data low
    logic               zero;    // constant low drive level
    logic [7:0]         rdata;   // read data
  } i2cmcp_host_t;

  i2cmcp_host_t q_reg;   // state
  i2cmcp_host_t q_next;  // next state
  logic         sda_s;   // synchronised data wire
  logic         qt;      // quarter-bit tick

  generate
    if (QUARTER_CYC < 2 || QUARTER_CYC > 65535) begin : g_chk
      $error("i2cmcp_host quarter count out of range");
    end
  endgenerate

  // data wire is a pin, two flops first
  i2cmcp_sync #(
    .WIDTH (1)
  ) u_sync (
    .CLK_IN   (CLK_IN),
    .RST_IN   (RST_IN),
    .ASYNC_IN (BUS.sda_line),
    .SYNC_OUT (sda_s)
  );

  assign qt = (q_reg.tick == 16'(QUARTER_CYC - 1));

  // register port and bit sequencer
  always_comb begin
    q_next       = q_reg;
    q_next.zero  = 1'b0;
    q_next.rdata = 8'h00;
    // read data for one cycle only
    if (RD_IN) begin
      if (ADDR_IN == HREG_TARGET) begin
        q_next.rdata = q_reg.target;
      end else if (ADDR_IN == HREG_INDEX) begin
        q_next.rdata = q_reg.index;
      end else if (ADDR_IN >= HREG_DATA0 && ADDR_IN <= HREG_DATA3) begin
        q_next.rdata = q_reg.data[2'(ADDR_IN - HREG_DATA0)];
      end else if (ADDR_IN == HREG_CTRL) begin
        q_next.rdata = {6'h00, q_reg.count};
      end else begin
        q_next.rdata = {3'h0, q_reg.acked, q_reg.nack, q_reg.busy};
      end
    end
    // writes refused while a transfer runs
    if (WR_IN && !q_reg.busy) begin
      if (ADDR_IN == HREG_TARGET) begin
        q_next.target = WDATA_IN;
      end else if (ADDR_IN == HREG_INDEX) begin
        q_next.index = WDATA_IN;
      end else if (ADDR_IN >= HREG_DATA0 && ADDR_IN <= HREG_DATA3) begin
        q_next.data[2'(ADDR_IN - HREG_DATA0)] = WDATA_IN;
      end else if (ADDR_IN == HREG_CTRL) begin
        q_next.count = WDATA_IN[1:0];
        if (WDATA_IN[CTRL_GO_BIT]) begin
          q_next.st    = H_START;
          q_next.busy  = 1'b1;
          q_next.nack  = 1'b0;
          q_next.acked = 3'h0;
          q_next.tick  = 16'h0000;
          q_next.phase = 2'h0;
        end
      end
    end
    // quarter-bit timebase, stopped when idle
    if (q_reg.st != H_IDLE) begin
      q_next.tick = qt ? 16'h0000 : 16'(q_reg.tick + 16'h0001);
    end
    if (qt && q_reg.st != H_IDLE) begin
      q_next.phase = 2'(q_reg.phase + 2'h1);
      case (q_reg.st)
        H_START: begin
          // data falls with clock high, then clock falls
          if (q_reg.phase == 2'h0) begin
            q_next.sda_low = 1'b1;
          end else begin
            q_next.scl_low = 1'b1;
            q_next.txb     = {q_reg.target[6:0], 1'b0};
            q_next.bitn    = 3'h0;
            q_next.byten   = 3'h0;
            q_next.phase   = 2'h0;
            q_next.st      = H_BIT;
          end
        end
        H_BIT: begin
          // set data while low, pulse clock, msb first
          case (q_reg.phase)
            2'h0: q_next.sda_low = !q_reg.txb[7];
            2'h1: q_next.scl_low = 1'b0;
            2'h2: q_next.scl_low = 1'b0;
            default: begin
              q_next.scl_low = 1'b1;
              q_next.txb     = {q_reg.txb[6:0], 1'b0};
              q_next.bitn    = 3'(q_reg.bitn + 3'h1);
              if (q_reg.bitn == 3'h7) begin
                q_next.st = H_ACK;
              end
            end
          endcase
        end
        H_ACK: begin
          // release data, sample ack while clock high
          case (q_reg.phase)
            2'h0: q_next.sda_low = 1'b0;
            2'h1: q_next.scl_low = 1'b0;
            2'h2: begin
              if (sda_s) begin
                q_next.nack = 1'b1;
              end else begin
                q_next.acked = 3'(q_reg.acked + 3'h1);
              end
            end
            default: begin
              q_next.scl_low = 1'b1;
              q_next.bitn    = 3'h0;
              q_next.byten   = 3'(q_reg.byten + 3'h1);
              // address and index precede the count plus one data bytes
              if (q_reg.nack ||
                  q_reg.byten == 3'({1'b0, q_reg.count} + 3'h2)) begin
                q_next.st = H_STOP;
              end else begin
                // index byte, then data bytes in order
                q_next.st  = H_BIT;
                q_next.txb = (q_reg.byten == 3'h0) ? q_reg.index :
                             q_reg.data[2'(q_reg.byten - 3'h1)];
              end
            end
          endcase
        end
        H_STOP: begin
          // data low, clock high, then data rises
          case (q_reg.phase)
            2'h0: q_next.sda_low = 1'b1;
            2'h1: q_next.scl_low = 1'b0;
            2'h2: q_next.sda_low = 1'b0;
            default: q_next.st   = H_FREE;
          endcase
        end
        default: begin
          // bus free time of two quarters
          if (q_reg.phase == 2'h1) begin
            q_next.st   = H_IDLE;
            q_next.busy = 1'b0;
            q_next.tick = 16'h0000;
          end
        end
      endcase
    end
  end

  // state register
  always_ff @(posedge CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      q_reg    <= '0;
      q_reg.st <= H_IDLE;
    end else begin
      q_reg <= q_next;
    end
  end

  // open-drain drive: enable means pull low
  assign BUS.scl_host_out = q_reg.zero;
  assign BUS.scl_host_oe  = q_reg.scl_low;
  assign BUS.sda_host_out = q_reg.zero;
  assign BUS.sda_host_oe  = q_reg.sda_low;
  assign RDATA_OUT        = q_reg.rdata;
  assign BUSY_OUT         = q_reg.busy;
endmodule // i2cmcp_host
`default_nettype wire

// >>> hdl/i2cmcp_if.sv
`timescale 1ns/1ps
`default_nettype none
// open-drain two-wire bus between controller and device
interface i2cmcp_if;
  logic scl_host_out;  // controller clock level when enabled
  logic scl_host_oe;   // controller pulls clock
  logic sda_host_out;  // controller data level when enabled
  logic sda_host_oe;   // controller pulls data
  logic sda_dev_out;   // device data level when enabled
  logic sda_dev_oe;    // device pulls data
  wire  scl_line;      // resolved clock wire, pulled up
  wire  sda_line;      // resolved data wire, pulled up

  // wired-and resolution of the drivers
  assign scl_line = !(scl_host_oe && !scl_host_out);
  assign sda_line = !(sda_host_oe && !sda_host_out) &&
                    !(sda_dev_oe && !sda_dev_out);

  modport host (output scl_host_out, scl_host_oe, sda_host_out,
                sda_host_oe, input scl_line, sda_line);
  modport device (output sda_dev_out, sda_dev_oe,
                  input scl_line, sda_line);
endinterface
`default_nettype wire

// >>> hdl/i2cmcp_pkg.sv
// Notes on behaviour
// - device is standard-mode slave, at most 100 kHz
// - address top six bits fixed, all seven bits compared
// - address low bit follows address-select pin
// - master frames start, address, data, stop
// - master always sends write bit zero
// - index byte first, then data bytes
// - all bytes eight bits, msb first
// - index advances by one per data byte
// - index past highest wraps to lowest
// - undefined index gets no acknowledge
// - index 30h never writable
// - master writes reserved bits as zero
// - gain register: reserved, restore, gain code
// - channel register: three-bit channel select
// - filter register: skip, resync, reserved bit
// - filter register: two-bit interface role
// - filter register: three-bit data format
// - restore written zero returns all defaults
// - resync zero holds converter in resync
// - skip one bypasses dc rejecting filter
package i2cmcp_pkg;

  // clock and bus timing
  localparam int CLK_PERIOD_NS   = 10;     // system clock period
  localparam int SCL_PERIOD_NS   = 10000;  // 100 kHz least period
  // quarter of a bit time, a least time so rounded up
  localparam int SCL_QUARTER_CYC =
    (SCL_PERIOD_NS + 4 * CLK_PERIOD_NS - 1) / (4 * CLK_PERIOD_NS);

  // framing
  localparam int          BYTE_BITS   = 8;      // bits per byte
  localparam logic [3:0]  BYTE_CNT    = 4'h8;   // bit counter at byte end
  localparam logic [5:0]  DEV_ADDR_HI = 6'h25;  // fixed address bits

  // register indexes
  localparam logic [7:0] IDX_GAIN   = 8'h31;  // gain_and_restore
  localparam logic [7:0] IDX_CHAN   = 8'h32;  // input_channel_select
  localparam logic [7:0] IDX_FILT   = 8'h33;  // filter_resync_interface

  // field positions
  localparam int RESTORE_BIT = 6;  // mode_regs_restore
  localparam int GAIN_MSB    = 5;  // gain_code top bit
  localparam int CHAN_MSB    = 2;  // input_channel_sel top bit
  localparam int SKIP_BIT    = 7;  // hpf_skip
  localparam int RESYNC_BIT  = 6;  // system_resync
  localparam int ROLE_MSB    = 4;  // interface_role top bit
  localparam int ROLE_LSB    = 3;  // interface_role low bit
  localparam int FMT_MSB     = 2;  // data_format_sel top bit

  // writable bits, unused_bit positions stay zero
  localparam logic [7:0] MASK_GAIN = 8'h7F;
  localparam logic [7:0] MASK_CHAN = 8'h07;
  localparam logic [7:0] MASK_FILT = 8'hDF;

  // reset values: restore and resync at normal, rest zero
  localparam logic [7:0] RST_GAIN = 8'h40;
  localparam logic [7:0] RST_CHAN = 8'h00;
  localparam logic [7:0] RST_FILT = 8'h40;

  // controller register map
  localparam logic [2:0] HREG_TARGET = 3'h0;  // target address
  localparam logic [2:0] HREG_INDEX  = 3'h1;  // register index byte
  localparam logic [2:0] HREG_DATA0  = 3'h2;  // first data byte
  localparam logic [2:0] HREG_DATA3  = 3'h5;  // last data byte
  localparam logic [2:0] HREG_CTRL   = 3'h6;  // count and go
  localparam logic [2:0] HREG_STATUS = 3'h7;  // busy, nack, acked
  localparam int         CTRL_GO_BIT = 7;     // go strobe bit

  // slave states
  typedef enum logic [2:0] {
    DEV_IDLE, DEV_ADDR, DEV_INDEX, DEV_DATA, DEV_ACK, DEV_IGNORE
  } i2cmcp_dev_state_t;

  // master states
  typedef enum logic [2:0] {
    H_IDLE, H_START, H_BIT, H_ACK, H_STOP, H_FREE
  } i2cmcp_host_state_t;

endpackage

// >>> hdl/i2cmcp_sync.sv
`timescale 1ns/1ps
`default_nettype none
// two-flop synchroniser for pin levels
module i2cmcp_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             CLK_IN,
  input  wire logic             RST_IN,
  input  wire logic [WIDTH-1:0] ASYNC_IN,
  output logic      [WIDTH-1:0] SYNC_OUT
);
  typedef struct packed {
    logic [WIDTH-1:0] meta_reg;  // first stage, read by second only
    logic [WIDTH-1:0] sync_reg;  // second stage
  } i2cmcp_sync_t;

  i2cmcp_sync_t q_reg;  // state
  i2cmcp_sync_t q_next; // next state

  generate
    if (WIDTH < 1) begin : g_chk
      $error("i2cmcp_sync width must be positive");
    end
  endgenerate

  // shift through both stages
  always_comb begin
    q_next          = q_reg;
    q_next.meta_reg = ASYNC_IN;
    q_next.sync_reg = q_reg.meta_reg;
  end

  // state register, bus idles high
  always_ff @(posedge CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      q_reg <= '1;
    end else begin
      q_reg <= q_next;
    end
  end

  assign SYNC_OUT = q_reg.sync_reg;
endmodule // i2cmcp_sync
`default_nettype wire

// >>> testbench/i2cmcp_properties.sv
`timescale 1ns/1ps
`default_nettype none
// wire checks on the joined two-wire bus
module i2cmcp_properties (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic scl_host_out,
  input wire logic scl_host_oe,
  input wire logic sda_host_out,
  input wire logic sda_host_oe,
  input wire logic sda_dev_out,
  input wire logic sda_dev_oe,
  input wire logic scl_line,
  input wire logic sda_line
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (rst_in);
  logic       scl_d;  // clock line one cycle back
  logic       sda_d;  // data line one cycle back
  logic [3:0] bits;   // clock rises in the byte, ninth wraps
  // count bit clocks, restart at each start
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      scl_d <= 1'b1;
      sda_d <= 1'b1;
      bits  <= 4'h0;
    end else begin
      scl_d <= scl_line;
      sda_d <= sda_line;
      if (scl_line && scl_d && sda_d && !sda_line)
        bits <= 4'h0;
      else if (scl_line && !scl_d)
        bits <= (bits == 4'h8) ? 4'h0 : bits + 4'h1;
    end
  end
  dev_low_a: assert property (sda_dev_oe |-> !sda_dev_out)
    else $error("device drives data high");
  host_low_a: assert property ((sda_host_oe |-> !sda_host_out) and
    (scl_host_oe |-> !scl_host_out)) else $error("controller drives high");
  ack_slot_a: assert property ($rose(sda_dev_oe) |-> bits == 4'h8)
    else $error("ack outside ninth bit");
  ack_still_a: assert property ((scl_line && $past(scl_line))
    |-> $stable(sda_dev_oe)) else $error("ack moved with clock high");
  ack_hold_a: assert property ($rose(sda_dev_oe) |-> sda_dev_oe[*8])
    else $error("ack too short");
  ack_end_a: assert property ($rose(sda_dev_oe) |->
    ##[16:48] !sda_dev_oe) else $error("ack not released");
  scl_high_a: assert property ($rose(scl_line) |-> scl_line[*6])
    else $error("clock high too short");
  scl_low_a: assert property ($fell(scl_line) |-> !scl_line[*6])
    else $error("clock low too short");
  start_c: cover property (scl_line && scl_d && sda_d && !sda_line);
  stop_c: cover property (scl_line && scl_d && !sda_d && sda_line);
  ack_c: cover property ($rose(sda_dev_oe));
endmodule // i2cmcp_properties
`default_nettype wire

// >>> testbench/test_i2c_mode_control_port.sv
`timescale 1ns/1ps
`default_nettype none
// controller drives the device; a byte model predicts the bank
module test_i2c_mode_control_port;
  import i2cmcp_pkg::*;
  logic       clk, rst, wr, rd, addr_sel, busy, restore, skip, resync, hold;
  logic [2:0] addr, chan, fmt;
  logic [7:0] wdata, rdata, st;
  logic [5:0] gain;
  logic [1:0] role;
  logic [7:0] m [3];   // model of the three registers
  logic [7:0] idx_tab [8] = '{8'h30, 8'h31, 8'h32, 8'h33,
                              8'h31, 8'h32, 8'h34, 8'h00};
  logic [7:0] msk [3] = '{8'h7F, 8'h07, 8'hDF};  // writable bits
  int         mismatches, checked, seed, i;
  logic [31:0] t;
  i2cmcp_if bus ();
  i2cmcp_device i2cmcp_device_inst (.CLK_IN(clk), .RST_IN(rst), .BUS(bus),
    .ADDR_SEL_IN(addr_sel), .GAIN_CODE_OUT(gain),
    .MODE_REGS_RESTORE_OUT(restore), .INPUT_CHANNEL_SEL_OUT(chan),
    .HPF_SKIP_OUT(skip), .SYSTEM_RESYNC_OUT(resync),
    .RESYNC_HOLD_OUT(hold), .INTERFACE_ROLE_OUT(role),
    .DATA_FORMAT_SEL_OUT(fmt));
  i2cmcp_host #(.QUARTER_CYC(8)) i2cmcp_host_inst (.CLK_IN(clk),
    .RST_IN(rst), .BUS(bus), .ADDR_IN(addr), .WDATA_IN(wdata),
    .WR_IN(wr), .RD_IN(rd), .RDATA_OUT(rdata), .BUSY_OUT(busy));
  i2cmcp_properties i2cmcp_properties_inst (.clk_in(clk), .rst_in(rst),
    .scl_host_out(bus.scl_host_out), .scl_host_oe(bus.scl_host_oe),
    .sda_host_out(bus.sda_host_out), .sda_host_oe(bus.sda_host_oe),
    .sda_dev_out(bus.sda_dev_out), .sda_dev_oe(bus.sda_dev_oe),
    .scl_line(bus.scl_line), .sda_line(bus.sda_line));
  // free running system clock
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task automatic wrap_up;
    if (mismatches == 0 && checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp) begin
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      mismatches++;
    end
  endtask
  // model back to power-up values
  task automatic defaults;
    m[0] = 8'h40;
    m[1] = 8'h00;
    m[2] = 8'h40;
  endtask
  // one-cycle register port strobes
  task automatic wr8(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rd8(input logic [2:0] a, output logic [7:0] d);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1 d = rdata;
  endtask
  task automatic cmp_all;
    chk({1'b0, restore, gain}, m[0]);
    chk({5'h00, chan}, m[1]);
    chk({skip, resync, 1'b0, role, fmt}, m[2]);
    chk({7'h00, hold}, {7'h00, !m[2][6]});
  endtask
  // whole write transfer, model updated byte by byte
  task automatic xfer(input logic [6:0] tgt, input logic [7:0] idx,
                      input int n, input bit keep);
    logic [7:0] d;
    int p, q, acks, k;
    wr8(HREG_TARGET, {1'b0, tgt});
    acks = (tgt == {DEV_ADDR_HI, addr_sel}) ? 1 : 0;
    p = -1;
    if (acks == 1 && idx >= 8'h31 && idx <= 8'h33) begin
      acks = 2;
      p = idx - 8'h31;
    end
    wr8(HREG_INDEX, idx);
    for (k = 0; k < n; k++) begin
      q = (p < 0) ? 0 : p;
      d = 8'($random(seed));
      d = d & msk[q];
      if (q == 0) d[6] = keep;
      wr8(HREG_DATA0 + k[2:0], d);
      if (p >= 0) begin
        acks++;
        if (q == 0 && !keep) defaults();
        else m[p] = d;
        p = (p == 2) ? 0 : p + 1;
      end
    end
    wr8(HREG_CTRL, {6'h20, 2'(n - 1)});
    #1;
    for (k = 0; k < 4000 && busy !== 1'b0; k++) begin
      @(posedge clk);
      #1;
    end
    if (busy !== 1'b0) begin
      // transfer never finished: count it and report at once
      chk({7'h00, busy}, 8'h00);
      wrap_up();
    end
    rd8(HREG_STATUS, st);
    chk(st, {3'b000, acks[2:0], acks < n + 2, 1'b0});
    cmp_all();
  endtask
  // reset, directed cases, random traffic, second reset
  initial begin
    {rst, wr, rd, addr, wdata, addr_sel} = {1'b1, 14'h0000};
    {mismatches, checked, seed} = {32'h0, 32'h0, 32'h0000E621};
    defaults();
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    repeat (3) @(posedge clk);
    #1 cmp_all();
    xfer({DEV_ADDR_HI, 1'b0}, 8'h31, 4, 1'b1);
    xfer({DEV_ADDR_HI, 1'b0}, 8'h33, 3, 1'b1);
    xfer({DEV_ADDR_HI, 1'b0}, 8'h30, 1, 1'b1);
    xfer({DEV_ADDR_HI, 1'b1}, 8'h32, 1, 1'b1);
    xfer({DEV_ADDR_HI, 1'b0}, 8'h31, 1, 1'b0);
    for (i = 0; i < 30; i++) begin
      @(posedge clk);
      t = $random(seed);
      addr_sel <= t[16];
      xfer({(t[3:0] == 4'h0) ? t[9:4] : DEV_ADDR_HI, t[10]},
           idx_tab[t[13:11]], 1 + t[15:14], 1'b1);
    end
    @(posedge clk);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    defaults();
    repeat (3) @(posedge clk);
    #1 cmp_all();
    wrap_up();
  end
endmodule // test_i2c_mode_control_port
`default_nettype wire
